/* File: ispc_codec.sv */
// Isolated SPI pulse codec: one channel and the dual top level
`timescale 1ns/1ps
`default_nettype none

module ispc_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Configuration
	input wire logic ctrl_sel,
	input wire logic clock_phase_setting,
	input wire logic clock_polarity_setting,
	input wire logic wake,
	// SPI pins
	input wire ispc_pkg::ispc_spi_in_t spi_in,
	output ispc_pkg::ispc_spi_out_t spi_out,
	// Line comparator levels and drive
	input wire logic rx_pos,
	input wire logic rx_neg,
	output ispc_pkg::ispc_line_drive_t line_out,
	output logic line_oe
);
	import ispc_pkg::*;

	typedef enum {TX_IDLE, TX_FIRST, TX_SECOND} ispc_tx_state_t;
	typedef enum {RX_IDLE, RX_FIRST, RX_GAP, RX_SECOND, RX_WAIT} ispc_rx_state_t;

	// Two-stage synchronisers for pins, wake and line levels
	logic [6:0] meta_ff;
	logic [6:0] sync_ff;
	logic cs_s, sck_s, pico_s, poci_s, rxp_s, rxn_s, wake_s;
	// synchronise inputs; CS resets to its idle high level
	// so that no false CS edge follows reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= 7'h40;
			sync_ff <= 7'h40;
		end else begin
			meta_ff <= {spi_in.cs_n, spi_in.sck, spi_in.pico, spi_in.poci,
				rx_pos, rx_neg, wake};
			sync_ff <= meta_ff;
		end
	end
	assign {cs_s, sck_s, pico_s, poci_s, rxp_s, rxn_s, wake_s} = sync_ff;

	// Previous synchronised pin levels for edge detection
	logic cs_d_ff, sck_d_ff, wake_d_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cs_d_ff <= 1'b1;
			sck_d_ff <= 1'b0;
			wake_d_ff <= 1'b0;
		end else begin
			cs_d_ff <= cs_s;
			sck_d_ff <= sck_s;
			wake_d_ff <= wake_s;
		end
	end

	// latching edge: rising when pha equals pol
	logic latch_edge;
	assign latch_edge = (clock_phase_setting == clock_polarity_setting) ? (sck_s && !sck_d_ff)
		: (!sck_s && sck_d_ff);

	// Transmit request from controller or peripheral logic
	ispc_pulse_t tx_req;
	logic tx_busy;
	ispc_pulse_t ret_req;
	// controller events; long only for CS
	// peripheral sends short -1 or wake long +1 only
	always_comb begin
		tx_req = PK_NONE;
		if (ctrl_sel) begin
			if (!cs_s && cs_d_ff)
				tx_req = PK_LONG_NEG;
			else if (cs_s && !cs_d_ff)
				tx_req = PK_LONG_POS;
			else if (!cs_s && latch_edge)
				tx_req = pico_s ? PK_SHORT_POS : PK_SHORT_NEG;
		end else if (wake_s && !wake_d_ff) begin
			tx_req = PK_LONG_POS;
		end else begin
			tx_req = ret_req;
		end
	end

	// Transmitter: a pulse pair of two equal halves
	ispc_tx_state_t tx_st_ff;
	logic [CNT_W-1:0] tx_cnt_ff;
	logic tx_first_pos_ff, tx_long_ff;
	function automatic logic [CNT_W-1:0] half_len(input logic is_long);
		half_len = is_long ? CNT_W'(HALF_LONG_CYC) : CNT_W'(HALF_SHORT_CYC);
	endfunction
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_st_ff <= TX_IDLE;
			tx_cnt_ff <= CNT_ZERO;
			tx_first_pos_ff <= 1'b0;
			tx_long_ff <= 1'b0;
		end else begin
			case (tx_st_ff)
			TX_IDLE: begin
				if (tx_req != PK_NONE) begin
					tx_long_ff <= (tx_req == PK_LONG_POS) || (tx_req == PK_LONG_NEG);
					tx_first_pos_ff <= (tx_req == PK_LONG_POS)
						|| (tx_req == PK_SHORT_POS);
					tx_cnt_ff <= half_len((tx_req == PK_LONG_POS)
						|| (tx_req == PK_LONG_NEG)) - CNT_ONE;
					tx_st_ff <= TX_FIRST;
				end
			end
			TX_FIRST: begin
				if (tx_cnt_ff == CNT_ZERO) begin
					tx_cnt_ff <= half_len(tx_long_ff) - CNT_ONE;
					tx_st_ff <= TX_SECOND;
				end else begin
					tx_cnt_ff <= tx_cnt_ff - CNT_ONE;
				end
			end
			TX_SECOND: begin
				if (tx_cnt_ff == CNT_ZERO)
					tx_st_ff <= TX_IDLE;
				else
					tx_cnt_ff <= tx_cnt_ff - CNT_ONE;
			end
			default: tx_st_ff <= TX_IDLE;
			endcase
		end
	end
	assign tx_busy = (tx_st_ff != TX_IDLE);

	// Line drive is registered so the pins never glitch
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_out <= '0;
			line_oe <= 1'b0;
		end else begin
			line_oe <= tx_busy;
			line_out.drive_pos <= (tx_st_ff == TX_FIRST) ? tx_first_pos_ff
				: (tx_st_ff == TX_SECOND) && !tx_first_pos_ff;
			line_out.drive_neg <= (tx_st_ff == TX_FIRST) ? !tx_first_pos_ff
				: (tx_st_ff == TX_SECOND) && tx_first_pos_ff;
		end
	end

	// Receiver: pulse timer on the comparator levels; own drive is ignored
	ispc_rx_state_t rx_st_ff;
	logic [CNT_W-1:0] rx_cnt_ff;
	logic rx_first_pos_ff, rx_long_ff;
	ispc_pulse_t rx_pulse;
	logic first_lvl, second_lvl;
	assign first_lvl = rx_first_pos_ff ? (rxp_s && !rxn_s) : (rxn_s && !rxp_s);
	assign second_lvl = rx_first_pos_ff ? (rxn_s && !rxp_s) : (rxp_s && !rxn_s);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_st_ff <= RX_IDLE;
			rx_cnt_ff <= CNT_ZERO;
			rx_first_pos_ff <= 1'b0;
			rx_long_ff <= 1'b0;
			rx_pulse <= PK_NONE;
		end else begin
			rx_pulse <= PK_NONE;
			case (rx_st_ff)
			RX_IDLE: begin
				if (!tx_busy && (rxp_s != rxn_s)) begin
					rx_first_pos_ff <= rxp_s;
					rx_cnt_ff <= CNT_ONE;
					rx_st_ff <= RX_FIRST;
				end
			end
			RX_FIRST: begin
				if (first_lvl) begin
					if (rx_cnt_ff >= CNT_W'(RX_MAX_HALF_CYC))
						rx_st_ff <= RX_WAIT;
					rx_cnt_ff <= rx_cnt_ff + CNT_ONE;
				end else if (rx_cnt_ff < CNT_W'(RX_MIN_SHORT_CYC)) begin
					rx_st_ff <= RX_IDLE;
				end else begin
					rx_long_ff <= (rx_cnt_ff >= CNT_W'(RX_MIN_LONG_CYC));
					rx_cnt_ff <= CNT_ZERO;
					rx_st_ff <= second_lvl ? RX_SECOND : RX_GAP;
				end
			end
			RX_GAP: begin
				if (second_lvl)
					rx_st_ff <= RX_SECOND;
				else if (rx_cnt_ff >= CNT_W'(INV_WINDOW_CYC))
					rx_st_ff <= RX_IDLE;
				else
					rx_cnt_ff <= rx_cnt_ff + CNT_ONE;
			end
			RX_SECOND: begin
				// Validated at the inversion point
				rx_pulse <= rx_long_ff
					? (rx_first_pos_ff ? PK_LONG_POS : PK_LONG_NEG)
					: (rx_first_pos_ff ? PK_SHORT_POS : PK_SHORT_NEG);
				rx_st_ff <= RX_WAIT;
			end
			// Rest of a pulse is not taken as a new first half
			RX_WAIT: begin
				if (rxp_s == rxn_s)
					rx_st_ff <= RX_IDLE;
			end
			default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	// fixed response delay after the inversion
	ispc_pulse_t dly_pulse_ff [RESP_DELAY_CYC];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < RESP_DELAY_CYC; i++)
				dly_pulse_ff[i] <= PK_NONE;
		end else begin
			dly_pulse_ff[0] <= rx_pulse;
			for (int i = 1; i < RESP_DELAY_CYC; i++)
				dly_pulse_ff[i] <= dly_pulse_ff[i-1];
		end
	end
	ispc_pulse_t act;
	assign act = dly_pulse_ff[RESP_DELAY_CYC-1];

	// Peripheral rebuild of CS, PICO, SCK and the return slot
	logic p_cs_ff, p_pico_ff, p_sck_act_ff, ret_pend_ff, ret_go;
	logic [CNT_W-1:0] sck_cnt_ff;
	// set PICO and start the SCK pulse in the same cycle, then return
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			p_cs_ff <= 1'b1;
			p_pico_ff <= 1'b0;
			p_sck_act_ff <= 1'b0;
			sck_cnt_ff <= CNT_ZERO;
			ret_pend_ff <= 1'b0;
		end else begin
			if (ret_go)
				ret_pend_ff <= 1'b0;
			if (ctrl_sel) begin
				p_cs_ff <= 1'b1;
				p_sck_act_ff <= 1'b0;
				sck_cnt_ff <= CNT_ZERO;
				ret_pend_ff <= 1'b0;
			end else if (sck_cnt_ff != CNT_ZERO) begin
				// Second SCK edge ends the pulse, then the bit returns
				if (sck_cnt_ff == CNT_ONE) begin
					p_sck_act_ff <= clock_phase_setting;
					ret_pend_ff <= 1'b1;
				end
				sck_cnt_ff <= sck_cnt_ff - CNT_ONE;
			end else begin
				case (act)
				PK_LONG_POS: begin
					p_cs_ff <= 1'b1;
					p_sck_act_ff <= 1'b0;
				end
				PK_LONG_NEG: begin
					// first return bit right after CS fall
					p_cs_ff <= 1'b0;
					p_sck_act_ff <= clock_phase_setting;
					ret_pend_ff <= 1'b1;
				end
				PK_SHORT_POS, PK_SHORT_NEG: begin
					p_pico_ff <= (act == PK_SHORT_POS);
					p_sck_act_ff <= !clock_phase_setting;
					sck_cnt_ff <= CNT_W'(SCK_PULSE_CYC);
				end
				default: begin
				end
				endcase
			end
		end
	end
	// POCI low returns short -1, high returns nothing
	// a bit is returned after every data bit
	// Return waits for a quiet line so it never collides with the pulse
	assign ret_go = ret_pend_ff && !tx_busy && !(wake_s && !wake_d_ff)
		&& (rx_st_ff == RX_IDLE) && !rxp_s && !rxn_s;
	assign ret_req = (ret_go && !poci_s) ? PK_SHORT_NEG : PK_NONE;

	// Controller POCI: null in a slot reads as 1
	logic c_poci_ff, slot_open_ff;
	logic [CNT_W-1:0] slot_cnt_ff;
	localparam int SLOT_CYC = RESP_DELAY_CYC + 2 * HALF_LONG_CYC;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			c_poci_ff <= 1'b1;
			slot_open_ff <= 1'b0;
			slot_cnt_ff <= CNT_ZERO;
		end else begin
			if (act == PK_SHORT_NEG) begin
				c_poci_ff <= 1'b0;
				slot_open_ff <= 1'b0;
			end else if (slot_open_ff && slot_cnt_ff == CNT_ZERO) begin
				c_poci_ff <= 1'b1;
				slot_open_ff <= 1'b0;
			end else if (slot_open_ff) begin
				slot_cnt_ff <= slot_cnt_ff - CNT_ONE;
			end
			// A slot opens once each transmitted pulse pair ends, except the long +1 sent on CS rise
			if (ctrl_sel && tx_st_ff == TX_SECOND && tx_cnt_ff == CNT_ZERO
				&& !(!tx_first_pos_ff && !tx_long_ff && 1'b0)
				&& !(tx_long_ff && tx_first_pos_ff)) begin
				slot_open_ff <= 1'b1;
				slot_cnt_ff <= CNT_W'(SLOT_CYC);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			spi_out <= '0;
		end else begin
			spi_out.cs_n <= p_cs_ff;
			spi_out.cs_n_oe <= !ctrl_sel;
			spi_out.sck <= clock_polarity_setting ^ p_sck_act_ff;
			spi_out.sck_oe <= !ctrl_sel;
			spi_out.pico <= p_pico_ff;
			spi_out.pico_oe <= !ctrl_sel;
			spi_out.poci <= c_poci_ff;
			spi_out.poci_oe <= ctrl_sel && !cs_s;
		end
	end
endmodule // ispc_channel

module ispc_dual_codec (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Per-channel configuration straps
	input wire logic [1:0] CONTROLLER_SIDE_SELECT,
	input wire logic [1:0] CLOCK_PHASE_SETTING,
	input wire logic [1:0] CLOCK_POLARITY_SETTING,
	input wire logic [1:0] WAKE,
	// SPI ports
	input wire ispc_pkg::ispc_spi_in_t [1:0] SPI_IN,
	output ispc_pkg::ispc_spi_out_t [1:0] SPI_OUT,
	// Line comparators and drivers
	input wire logic [1:0] LINE_PLUS_RX,
	input wire logic [1:0] LINE_MINUS_RX,
	output ispc_pkg::ispc_line_drive_t [1:0] LINE_DRIVE,
	output logic [1:0] LINE_OE
);
	import ispc_pkg::*;
	// two channels, no shared state; modes set per channel
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		ispc_channel u_chan (
			.clk(CLK),
			.nrst(NRST),
			.ctrl_sel(CONTROLLER_SIDE_SELECT[ch]),
			.clock_phase_setting(CLOCK_PHASE_SETTING[ch]),
			.clock_polarity_setting(CLOCK_POLARITY_SETTING[ch]),
			.wake(WAKE[ch]),
			.spi_in(SPI_IN[ch]),
			.spi_out(SPI_OUT[ch]),
			.rx_pos(LINE_PLUS_RX[ch]),
			.rx_neg(LINE_MINUS_RX[ch]),
			.line_out(LINE_DRIVE[ch]),
			.line_oe(LINE_OE[ch])
		);
	end
endmodule // ispc_dual_codec

`default_nettype wire

/* File: ispc_pkg.sv */
// Package for the isolated SPI pulse codec: timing, types and line codes
package ispc_pkg;
	// Clock period in picoseconds (250 MHz)
	localparam int CLK_PERIOD_PS = 4000;
	// Half-pulse widths as transmitted, in nanoseconds
	localparam int HALF_LONG_NS = 150;
	localparam int HALF_SHORT_NS = 50;
	localparam int HALF_LONG_CYC = (HALF_LONG_NS * 1000) / CLK_PERIOD_PS;
	localparam int HALF_SHORT_CYC = (HALF_SHORT_NS * 1000) / CLK_PERIOD_PS;
	// Receive thresholds: least half width for short and long pulses
	localparam int RX_MIN_SHORT_NS = 30;
	localparam int RX_MIN_LONG_NS = 100;
	localparam int RX_MIN_SHORT_CYC =
		(RX_MIN_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RX_MIN_LONG_CYC =
		(RX_MIN_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Longest accepted first half before the inversion must begin
	localparam int RX_MAX_HALF_NS = 250;
	localparam int RX_MAX_HALF_CYC = (RX_MAX_HALF_NS * 1000) / CLK_PERIOD_PS;
	// Longest gap of null allowed at the inversion point
	localparam int INV_WINDOW_NS = 20;
	localparam int INV_WINDOW_CYC = (INV_WINDOW_NS * 1000) / CLK_PERIOD_PS;
	// Response delay after the inversion point
	localparam int RESP_DELAY_NS = 60;
	localparam int RESP_DELAY_CYC = (RESP_DELAY_NS * 1000) / CLK_PERIOD_PS;
	// Width of the rebuilt SCK pulse on the peripheral side
	localparam int SCK_PULSE_NS = 100;
	localparam int SCK_PULSE_CYC = (SCK_PULSE_NS * 1000) / CLK_PERIOD_PS;
	// Counter width, enough for every count above
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

	// Pulse kinds passed between encoder, decoder and SPI logic
	typedef enum logic [2:0] {
		PK_NONE,
		PK_LONG_POS,
		PK_LONG_NEG,
		PK_SHORT_POS,
		PK_SHORT_NEG
	} ispc_pulse_t;

	// Line drive: both low means zero volts between the pins
	typedef struct packed {
		logic drive_pos;
		logic drive_neg;
	} ispc_line_drive_t;

	// SPI port pins of one channel, outputs with their enables
	typedef struct packed {
		logic cs_n;
		logic cs_n_oe;
		logic sck;
		logic sck_oe;
		logic pico;
		logic pico_oe;
		logic poci;
		logic poci_oe;
	} ispc_spi_out_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic pico;
		logic poci;
	} ispc_spi_in_t;
endpackage : ispc_pkg

/* File: ispc_dual_codec_asserts.sv */
// Port checker for the dual pulse codec
`timescale 1ns/1ps
`default_nettype none
module ispc_dual_codec_asserts (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Straps and pins
	input wire logic [1:0] CONTROLLER_SIDE_SELECT,
	input wire ispc_pkg::ispc_spi_in_t [1:0] SPI_IN,
	input wire ispc_pkg::ispc_spi_out_t [1:0] SPI_OUT,
	// Line side
	input wire ispc_pkg::ispc_line_drive_t [1:0] LINE_DRIVE,
	input wire logic [1:0] LINE_OE
);
	import ispc_pkg::*;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	for (genvar g = 0; g < 2; g++) begin : g_ch
		logic [1:0] cur;
		logic [1:0] last_ff;
		logic [CNT_W-1:0] run_ff;
		logic [CNT_W-1:0] w1_ff;
		logic half2_ff;
		logic chg;
		assign cur = LINE_DRIVE[g];
		assign chg = last_ff != 2'h0 && cur != last_ff;
		// Run length of each drive level, so half widths can be judged
		always_ff @(posedge CLK or negedge NRST) begin
			if (!NRST) begin
				last_ff <= 2'h0;
				run_ff <= CNT_ONE;
			end else begin
				last_ff <= cur;
				run_ff <= (cur != 2'h0 && cur == last_ff) ? run_ff + CNT_ONE : CNT_ONE;
			end
		end
		// Which half is on the line, and how long the first one was
		always_ff @(posedge CLK or negedge NRST) begin
			if (!NRST) begin
				half2_ff <= 1'h0;
				w1_ff <= CNT_ZERO;
			end else begin
				half2_ff <= (cur == 2'h0) ? 1'h0 : (half2_ff | chg);
				w1_ff <= (chg && !half2_ff) ? run_ff : w1_ff;
			end
		end
		AST_NO_SHORT: assert property (cur != 2'h3)
			else $error("line driven both ways");
		AST_OE_DRIVE: assert property (cur != 2'h0 |-> LINE_OE[g])
			else $error("line driven without enable");
		AST_HALF_WIDTH: assert property (chg |-> run_ff == HALF_SHORT_CYC || run_ff == HALF_LONG_CYC)
			else $error("half width wrong");
		AST_PAIR_INVERTS: assert property (chg && !half2_ff |-> cur == ~last_ff)
			else $error("first half not followed by inverse");
		AST_PAIR_ENDS: assert property (chg && half2_ff |-> cur == 2'h0 && run_ff == w1_ff)
			else $error("pair not symmetric or not ending at zero");
		AST_NO_SHORT_POS: assert property (chg && !half2_ff && last_ff == 2'h2 && !CONTROLLER_SIDE_SELECT[g] |-> run_ff != HALF_SHORT_CYC)
			else $error("peripheral sent short plus pulse");
		AST_NO_LONG_NEG: assert property (chg && !half2_ff && last_ff == 2'h1 && !CONTROLLER_SIDE_SELECT[g] |-> run_ff != HALF_LONG_CYC)
			else $error("peripheral sent long minus pulse");
		AST_POCI_HIZ: assert property ((CONTROLLER_SIDE_SELECT[g] && SPI_IN[g].cs_n) [*5] |-> !SPI_OUT[g].poci_oe)
			else $error("controller drives poci while deselected");
		AST_CTRL_DIR: assert property (CONTROLLER_SIDE_SELECT[g] [*4] |-> !(SPI_OUT[g].cs_n_oe | SPI_OUT[g].sck_oe | SPI_OUT[g].pico_oe))
			else $error("controller drives an input pin");
		AST_PERIPH_DIR: assert property (!CONTROLLER_SIDE_SELECT[g] [*4] |-> SPI_OUT[g].cs_n_oe && SPI_OUT[g].sck_oe && SPI_OUT[g].pico_oe && !SPI_OUT[g].poci_oe)
			else $error("peripheral pin directions wrong");
	end
endmodule // ispc_dual_codec_asserts
bind ispc_dual_codec ispc_dual_codec_asserts i_ispc_dual_codec_asserts (
	.CLK(CLK), .NRST(NRST), .CONTROLLER_SIDE_SELECT(CONTROLLER_SIDE_SELECT),
	.SPI_IN(SPI_IN), .SPI_OUT(SPI_OUT), .LINE_DRIVE(LINE_DRIVE),
	.LINE_OE(LINE_OE));
`default_nettype wire

/* File: ispc_line_peer.sv */
// Cable joining the two channels, with a test pulse source
`timescale 1ns/1ps
`default_nettype none
module ispc_line_peer (
	// Drives of both channels
	input wire ispc_pkg::ispc_line_drive_t [1:0] drive,
	input wire logic [1:0] oe,
	// Pulse injected toward channel 1
	input wire ispc_pkg::ispc_line_drive_t inj,
	// Comparator levels seen by each channel
	output logic [1:0] rx_pos,
	output logic [1:0] rx_neg
);
	import ispc_pkg::*;
	logic p1;
	logic n1;
	// window comparator
	// Opposing drives of channel 0 and the injector cancel, so such a collision reads as null at channel 1, not a pulse
	assign p1 = (drive[0].drive_pos & oe[0]) | inj.drive_pos;
	assign n1 = (drive[0].drive_neg & oe[0]) | inj.drive_neg;
	assign rx_pos[1] = p1 & ~n1;
	assign rx_neg[1] = n1 & ~p1;
	assign rx_pos[0] = drive[1].drive_pos & ~drive[1].drive_neg & oe[1];
	assign rx_neg[0] = drive[1].drive_neg & ~drive[1].drive_pos & oe[1];
endmodule // ispc_line_peer
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the dual pulse codec
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ispc_pkg::*;
	localparam int B_CS = 7;
	localparam int B_SCK = 5;
	localparam int B_PICO = 3;
	localparam int B_POCI = 1;
	logic clk;
	logic nrst;
	logic [1:0] ctrl_sel, clock_phase_setting, clock_polarity_setting, wake, lp, lm, loe;
	ispc_spi_in_t [1:0] spi_in;
	ispc_spi_out_t [1:0] spi_out;
	ispc_line_drive_t [1:0] ld;
	ispc_line_drive_t inj;
	int err_count;
	int total_checks;
	int n;

	ispc_dual_codec i_ispc_dual_codec (.CLK(clk), .NRST(nrst),
		.CONTROLLER_SIDE_SELECT(ctrl_sel), .CLOCK_PHASE_SETTING(clock_phase_setting),
		.CLOCK_POLARITY_SETTING(clock_polarity_setting), .WAKE(wake), .SPI_IN(spi_in),
		.SPI_OUT(spi_out), .LINE_PLUS_RX(lp), .LINE_MINUS_RX(lm),
		.LINE_DRIVE(ld), .LINE_OE(loe));
	ispc_line_peer i_ispc_line_peer (.drive(ld), .oe(loe), .inj(inj),
		.rx_pos(lp), .rx_neg(lm));

	// 250 MHz clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	// Compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Step past rising edges; inputs and samples land 1 ns later
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Catch one pulse pair on a channel and measure both halves
	task automatic pulse(input int ch, input logic [1:0] ef, input int eh);
		logic [1:0] f;
		int h1;
		int h2;
		int k;
		h1 = 0;
		h2 = 0;
		for (k = 0; k < 800 && ld[ch] === 2'h0; k++) tick(1);
		f = ld[ch];
		for (; ld[ch] === f && h1 < 99; h1++) tick(1);
		for (; ld[ch] === ~f && h2 < 99; h2++) tick(1);
		check("first level", f, ef);
		check("first half", h1, eh);
		check("second half", h2, eh);
	endtask

	// Wait, bounded, for one port pin to reach a level
	task automatic wait_bit(input int ch, input int idx, input logic v, input int lim);
		for (n = 0; n < lim && spi_out[ch][idx] !== v; n++) tick(1);
		check("spi pin", spi_out[ch][idx], v);
	endtask

	// Drive a pair in the peer's place, with an optional null gap
	task automatic inject(input logic [1:0] f, input int h, input int gap);
		inj = f;
		tick(h);
		inj = 2'h0;
		tick(gap);
		inj = ~f;
		tick(h);
		inj = 2'h0;
		tick(80);
	endtask

	// Cut a hung run short
	initial begin
		#80000;
		err_count++;
		results();
	end

	// Main sequence
	initial begin
		err_count = 0;
		total_checks = 0;
		nrst = 1'h0;
		// controller mode 0, peripheral mode 3
		ctrl_sel = 2'h1;
		clock_phase_setting = 2'h2;
		clock_polarity_setting = 2'h2;
		wake = 2'h0;
		spi_in = '0;
		spi_in[0].cs_n = 1'h1;
		inj = '0;
		tick(4);
		nrst = 1'h1;
		tick(4);
		check("periph cs", spi_out[1].cs_n, 1'h1);
		check("periph sck idle", spi_out[1].sck, 1'h1);
		check("ctrl poci oe", spi_out[0].poci_oe, 1'h0);
		spi_in[0].cs_n = 1'h0;
		pulse(0, 2'h1, HALF_LONG_CYC);
		pulse(1, 2'h1, HALF_SHORT_CYC);
		check("cs before return", spi_out[1].cs_n, 1'h0);
		check("sck left idle", spi_out[1].sck, 1'h0);
		wait_bit(0, B_POCI, 1'h0, 100);
		tick(40);
		// Two data bits; peripheral returns the same value
		for (int b = 1; b >= 0; b--) begin
			spi_in[1].poci = b[0];
			spi_in[0].pico = b[0];
			tick(2);
			spi_in[0].sck = 1'h1;
			pulse(0, b ? 2'h2 : 2'h1, HALF_SHORT_CYC);
			wait_bit(1, B_PICO, b[0], 60);
			wait_bit(1, B_SCK, 1'h1, 60);
			check("pico at sck", spi_out[1].pico, b[0]);
			if (b == 0) pulse(1, 2'h1, HALF_SHORT_CYC);
			wait_bit(0, B_POCI, b[0], 200);
			spi_in[0].sck = 1'h0;
			tick(60);
		end
		spi_in[0].cs_n = 1'h1;
		pulse(0, 2'h2, HALF_LONG_CYC);
		wait_bit(1, B_CS, 1'h1, 60);
		check("sck idle again", spi_out[1].sck, 1'h1);
		check("ctrl poci oe", spi_out[0].poci_oe, 1'h0);
		tick(80);
		inject(2'h2, 4, 0);
		check("too short", spi_out[1].pico, 1'h0);
		inject(2'h1, 70, 0);
		check("too long", spi_out[1].cs_n, 1'h1);
		inject(2'h2, HALF_SHORT_CYC, 8);
		check("late inversion", spi_out[1].pico, 1'h0);
		inj = 2'h2;
		tick(HALF_SHORT_CYC);
		inj = 2'h1;
		wait_bit(1, B_PICO, 1'h1, 60);
		inj = 2'h0;
		check("delay", n >= RESP_DELAY_CYC && n <= RESP_DELAY_CYC + 6, 1'h1);
		tick(120);
		wake[1] = 1'h1;
		pulse(1, 2'h2, HALF_LONG_CYC);
		wake[1] = 1'h0;
		// Swap roles: peripheral mode 2 on 0, controller mode 1 on 1
		nrst = 1'h0;
		ctrl_sel = 2'h2;
		clock_polarity_setting = 2'h1;
		spi_in = '0;
		spi_in[1].cs_n = 1'h1;
		tick(4);
		nrst = 1'h1;
		tick(4);
		check("mode 2 idle", spi_out[0].sck, 1'h1);
		spi_in[1].cs_n = 1'h0;
		pulse(1, 2'h1, HALF_LONG_CYC);
		wait_bit(0, B_CS, 1'h0, 60);
		tick(100);
		results();
	end
endmodule // tb_top
`default_nettype wire
